// >>> wdt_timer.sv
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "wdt_defs.svh"

module wdt_timer
   import wdt_pkg::*;
(
   input  wire logic                   I_CLK_SYS,
   input  wire logic                   I_RST,
   input  wire logic                   I_PSEL,
   input  wire logic                   I_PENABLE,
   input  wire logic                   I_PWRITE,
   input  wire logic [`WDT_ADDR_W-1:0] I_PADDR,
   input  wire logic [31:0]            I_PWDATA,
   output logic                        O_PREADY,
   output logic [31:0]                 O_PRDATA,
   output logic                        O_PSLVERR,
   output logic                        O_PREWARN,
   output logic                        O_RESET_REQ
);

   wdt_state_type st_r;     // registered state
   wdt_state_type st_nxt;   // next state

   logic access;            // apb access phase, answer edge
   logic wr;                // write takes effect this edge
   logic mapped;            // address hits a register
   logic srv;               // service command
   logic dis_cmd;           // watchdog_disable_cmd
   logic en_cmd;            // watchdog_enable_cmd
   logic tick;              // prescaler output enable pulse
   logic ovf;               // counter leaves all ones
   logic [`WDT_PRE_W-1:0] pre_max;  // terminal prescaler count

   // bus decode; the slave answers one cycle into the access phase
   always_comb
   begin
      access  = I_PSEL & I_PENABLE & st_r.pready;
      wr      = access & I_PWRITE;
      mapped  = (I_PADDR == `WDT_OFS_CTRL)   ||
                (I_PADDR == `WDT_OFS_CMD)    ||
                (I_PADDR == `WDT_OFS_RELOAD) ||
                (I_PADDR == `WDT_OFS_STATUS);
      srv     = wr & (I_PADDR == `WDT_OFS_CMD)
                   & I_PWDATA[`WDT_CMD_SRV_BIT];
      dis_cmd = wr & (I_PADDR == `WDT_OFS_CMD)
                   & I_PWDATA[`WDT_CMD_DIS_BIT];
      en_cmd  = wr & (I_PADDR == `WDT_OFS_CMD)
                   & I_PWDATA[`WDT_CMD_EN_BIT];
   end

   // prescaler tick and overflow detection
   always_comb
   begin
      pre_max = st_r.sel ? `WDT_PRE_MAX_FAST : `WDT_PRE_MAX_SLOW;
      tick    = st_r.en & ((st_r.presc & pre_max) == pre_max);
      ovf     = tick & (st_r.cnt == `WDT_CNT_MAX);
   end

   // next-state logic for counter, flags and bus
   always_comb
   begin
      st_nxt = st_r;

      // registers written by software
      if (wr && I_PADDR == `WDT_OFS_CTRL)
      begin
         st_nxt.sel = I_PWDATA[`WDT_CTRL_SEL_BIT];
      end
      if (wr && I_PADDR == `WDT_OFS_RELOAD)
      begin
         st_nxt.reload = I_PWDATA[`WDT_CNT_W-1:0];
      end

      if (dis_cmd)
      begin
         st_nxt.en = 1'b0;
      end
      if (en_cmd)
      begin
         // enable wins a combined write: fail-safe side
         st_nxt.en = 1'b1;
      end

      // counting; the whole chain freezes while disabled
      if (st_r.en)
      begin
         st_nxt.presc = st_r.presc + `WDT_PRE_STEP;
         if (tick)
         begin
            st_nxt.cnt = st_r.cnt + `WDT_CNT_STEP;
         end
         if (ovf)
         begin
            st_nxt.cnt = st_r.reload;
         end
      end

      if (srv)
      begin
         st_nxt.cnt     = st_r.reload;
         st_nxt.presc   = '0;
         st_nxt.prewarn = 1'b0;
      end

      if (ovf)
      begin
         // the event wins over a service in the same cycle
         if (st_r.prewarn)
         begin
            st_nxt.rstreq = 1'b1;
         end
         st_nxt.prewarn = 1'b1;
      end

      // apb: ready one cycle into access, then drop
      st_nxt.pready  = I_PSEL & I_PENABLE & ~st_r.pready;
      st_nxt.pslverr = I_PSEL & I_PENABLE & ~st_r.pready & ~mapped;
      st_nxt.prdata  = 32'h0000_0000;
      if (I_PSEL && I_PENABLE && !st_r.pready && !I_PWRITE)
      begin
         case (I_PADDR)
            `WDT_OFS_CTRL:
            begin
               st_nxt.prdata[`WDT_CTRL_SEL_BIT] = st_r.sel;
            end
            `WDT_OFS_RELOAD:
            begin
               st_nxt.prdata[`WDT_CNT_W-1:0] = st_r.reload;
            end
            `WDT_OFS_STATUS:
            begin
               st_nxt.prdata[`WDT_ST_EN_BIT] = st_r.en;
               st_nxt.prdata[`WDT_ST_PW_BIT] = st_r.prewarn;
               st_nxt.prdata[`WDT_ST_RR_BIT] = st_r.rstreq;
               st_nxt.prdata[`WDT_ST_CNT_LSB +: `WDT_CNT_W] = st_r.cnt;
            end
            default:
            begin
               // cmd and unmapped addresses read as zero
               st_nxt.prdata = 32'h0000_0000;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge I_CLK_SYS or posedge I_RST)
   begin
      if (I_RST)
      begin
         st_r         <= '0;
         st_r.en      <= 1'b1;
         st_r.sel     <= `WDT_RST_SEL;
         st_r.reload  <= `WDT_RST_RELOAD;
         st_r.cnt     <= `WDT_RST_RELOAD;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state flops
   assign O_PREADY    = st_r.pready;
   assign O_PRDATA    = st_r.prdata;
   assign O_PSLVERR   = st_r.pslverr;
   assign O_PREWARN   = st_r.prewarn;
   assign O_RESET_REQ = st_r.rstreq;

   // checks on the block's own behaviour
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RST);

   reset_enable_a: assert property (
      $fell(I_RST) |-> st_r.en && st_r.cnt == `WDT_RST_RELOAD)
      else $error("not enabled after reset");

   disable_freeze_a: assert property (
      !st_r.en && !srv |=> $stable(st_r.cnt) && $stable(st_r.presc))
      else $error("counter moved while disabled");

   enable_cmd_a: assert property (
      en_cmd |=> st_r.en ##1 (st_r.en || $past(dis_cmd)))
      else $error("enable command not taken");

   prewarn_first_a: assert property (
      ovf && !st_r.prewarn && !st_r.rstreq |=> st_r.prewarn && !st_r.rstreq)
      else $error("prewarning not first on overflow");

   reset_second_a: assert property (
      ovf && st_r.prewarn |=> st_r.rstreq [*3])
      else $error("reset request missing on second overflow");

   service_reload_a: assert property (
      srv |=> st_r.presc == '0 && st_r.cnt == $past(st_r.reload))
      else $error("service did not reload");

   tick_step_a: assert property (
      tick && !srv && !ovf |=> st_r.cnt == $past(st_r.cnt) + 16'h0001)
      else $error("counter did not step on tick");

   fast_ratio_a: assert property (
      st_r.en && st_r.sel && st_r.presc[7:0] != 8'hff |-> !tick)
      else $error("tick off the 256 boundary");

   apb_answer_a: assert property (
      I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY ##1 !O_PREADY)
      else $error("apb answer not one cycle");

   cov_service_c: cover property (srv && st_r.en);
   cov_prewarn_c: cover property (ovf && !st_r.prewarn);
   cov_reset_c:   cover property (ovf && st_r.prewarn);
   // a disabled stretch spans hundreds of clocks, so the window is wide
   cov_disable_c: cover property (dis_cmd ##[1:1000] en_cmd);

endmodule : wdt_timer

// >>> wdt_defs.svh
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// register byte offsets on the apb bus
`define WDT_OFS_CTRL      8'h00
`define WDT_OFS_CMD       8'h04
`define WDT_OFS_RELOAD    8'h08
`define WDT_OFS_STATUS    8'h0c

// ctrl fields
`define WDT_CTRL_SEL_BIT  0

// cmd fields, write-only strobes
`define WDT_CMD_SRV_BIT   0
`define WDT_CMD_DIS_BIT   1
`define WDT_CMD_EN_BIT    2

// status fields
`define WDT_ST_EN_BIT     0
`define WDT_ST_PW_BIT     1
`define WDT_ST_RR_BIT     2
`define WDT_ST_CNT_LSB    16

// widths
`define WDT_CNT_W         16
`define WDT_PRE_W         14
`define WDT_ADDR_W        8

// prescaler terminal masks: divide by 16384 or by 256
`define WDT_PRE_MAX_SLOW  14'h3fff
`define WDT_PRE_MAX_FAST  14'h00ff

// reset values: 256 ticks of 256 clocks give 6.55 ms at 10 MHz
`define WDT_RST_SEL       1'b1
`define WDT_RST_RELOAD    16'hff00
`define WDT_CNT_MAX       16'hffff

// single steps for the prescaler and the counter, sized to their widths
`define WDT_PRE_STEP      14'h0001
`define WDT_CNT_STEP      16'h0001

`endif

// >>> wdt_pkg.sv
`include "wdt_defs.svh"

package wdt_pkg;

   // complete state of the watchdog, registered as one word
   typedef struct packed {
      logic [`WDT_PRE_W-1:0] presc;    // prescaler
      logic [`WDT_CNT_W-1:0] cnt;      // watchdog counter
      logic [`WDT_CNT_W-1:0] reload;   // watchdog_reload_value
      logic                  en;       // counting enabled
      logic                  sel;      // 1: divide by 256
      logic                  prewarn;  // prewarning request
      logic                  rstreq;   // reset request
      logic                  pready;   // apb ready
      logic                  pslverr;  // apb error
      logic [31:0]           prdata;   // apb read data
   } wdt_state_type;

endpackage : wdt_pkg

// >>> wdt_timer_tb_top.sv
`timescale 1ns/100ps
`include "wdt_defs.svh"

module wdt_timer_tb_top;
   logic        clk;       // system clock
   logic        rst;       // async reset, active high
   logic        psel;      // apb select
   logic        penable;   // apb enable
   logic        pwrite;    // apb direction
   logic [7:0]  paddr;     // apb byte address
   logic [31:0] pwdata;    // apb write data
   logic        pready;    // apb ready
   logic [31:0] prdata;    // apb read data
   logic        pslverr;   // apb error
   logic        prewarn;   // prewarning request
   logic        rstreq;    // reset request
   logic [31:0] rdat;      // last read data
   logic        rerr;      // last error flag
   int          bad_count; // mismatches
   int          n_checks;  // comparisons

   wdt_timer wdt_timer_i (.I_CLK_SYS(clk), .I_RST(rst), .I_PSEL(psel),
      .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
      .I_PWDATA(pwdata), .O_PREADY(pready), .O_PRDATA(prdata),
      .O_PSLVERR(pslverr), .O_PREWARN(prewarn), .O_RESET_REQ(rstreq));

   // 40 mhz clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task end_sim;
      if (bad_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_sim

   task chk(input logic [31:0] s, input logic [31:0] x);
      n_checks++;
      if (s !== x)
      begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask : chk

   // one apb transfer; read data and error are taken at the edge that
   // samples ready high, and the request is released only after it
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      if (n == 20)
      begin
         bad_count++;
         end_sim;
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // bounded wait for prewarn (r=0) or reset request (r=1)
   task wait_hi(input logic r, input int lim);
      int n;
      for (n = 0; n < lim; n++)
      begin
         @(posedge clk);
         #1;
         if ((r ? rstreq : prewarn) === 1'b1)
            break;
      end
      if (n == lim)
      begin
         bad_count++;
         end_sim;
      end
   endtask : wait_hi

   task do_reset;
      @(posedge clk);
      rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
   endtask : do_reset

   // defaults after reset, counting without software help
   task t_reset;
      apb(1'b0, `WDT_OFS_CTRL, 32'h0);
      chk(rdat, 32'h1);
      apb(1'b0, `WDT_OFS_RELOAD, 32'h0);
      chk(rdat, 32'h0000ff00);
      apb(1'b0, `WDT_OFS_STATUS, 32'h0);
      chk(rdat, 32'hff000001);
      chk({prewarn, rstreq}, 2'b00);
   endtask : t_reset

   // unmapped place refused, command register reads zero
   task t_unmapped;
      apb(1'b1, 8'h10, 32'hffffffff);
      chk(rerr, 1'b1);
      apb(1'b0, 8'h10, 32'h0);
      chk(rerr, 1'b1);
      chk(rdat, 32'h0);
      apb(1'b0, `WDT_OFS_CMD, 32'h0);
      chk(rerr, 1'b0);
      chk(rdat, 32'h0);
   endtask : t_unmapped

   // short reload: count up, prewarning, then reset request
   task t_overflow;
      apb(1'b1, `WDT_OFS_RELOAD, 32'h0000fffe);
      apb(1'b1, `WDT_OFS_CMD, 32'h1);
      repeat (300) @(posedge clk);
      apb(1'b0, `WDT_OFS_STATUS, 32'h0);
      chk(rdat, 32'hffff0001);
      chk(prewarn, 1'b0);
      wait_hi(1'b0, 300);
      chk(rstreq, 1'b0);
      wait_hi(1'b1, 600);
      chk(prewarn, 1'b1);
      apb(1'b1, `WDT_OFS_CMD, 32'h1);
      #1;
      chk({prewarn, rstreq}, 2'b01);
      do_reset;
      #1;
      chk(rstreq, 1'b0);
   endtask : t_overflow

   // disable freezes the count, enable with service resumes it
   task t_disable;
      logic [31:0] q;
      apb(1'b1, `WDT_OFS_CMD, 32'h2);
      apb(1'b0, `WDT_OFS_STATUS, 32'h0);
      q = rdat;
      chk(q[0], 1'b0);
      repeat (600) @(posedge clk);
      apb(1'b0, `WDT_OFS_STATUS, 32'h0);
      chk(rdat, q);
      apb(1'b1, `WDT_OFS_CMD, 32'h5);
      repeat (600) @(posedge clk);
      apb(1'b0, `WDT_OFS_STATUS, 32'h0);
      chk(rdat, 32'hff020001);
   endtask : t_disable

   // timely service keeps the flags low; a missed one gives a prewarning
   task t_service;
      apb(1'b1, `WDT_OFS_RELOAD, 32'h0000ffff);
      repeat (3)
      begin
         apb(1'b1, `WDT_OFS_CMD, 32'h1);
         repeat (200) @(posedge clk);
         chk(prewarn, 1'b0);
      end
      wait_hi(1'b0, 300);
      chk(rstreq, 1'b0);
   endtask : t_service

   // slow prescaler: first overflow near 16384 clocks
   task t_slow;
      apb(1'b1, `WDT_OFS_CTRL, 32'h0);
      apb(1'b1, `WDT_OFS_RELOAD, 32'h0000ffff);
      apb(1'b1, `WDT_OFS_CMD, 32'h1);
      repeat (16000) @(posedge clk);
      chk(prewarn, 1'b0);
      wait_hi(1'b0, 800);
      apb(1'b0, `WDT_OFS_CTRL, 32'h0);
      chk(rdat, 32'h0);
   endtask : t_slow

   // main sequence
   initial
   begin
      bad_count = 0;
      n_checks = 0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      do_reset;
      t_reset;
      t_unmapped;
      t_overflow;
      t_reset;
      t_disable;
      t_service;
      t_slow;
      end_sim;
   end
endmodule : wdt_timer_tb_top
